// [inc/tmh_pkg.sv]
// Shared constants and types for the tuning and manual output handshake.
`default_nettype none
package tmh_pkg;
    localparam int unsigned PARAM_W    = 16;
    localparam int unsigned MV_W       = 32;
    localparam int unsigned N_TUNE     = 4;
    // Tuning request bit positions.
    localparam int unsigned TUNE_FULL  = 0;
    localparam int unsigned TUNE_HALF  = 1;
    localparam int unsigned TUNE_FILT  = 2;
    localparam int unsigned TUNE_DIST  = 3;
    localparam logic [PARAM_W-1:0] PARAM_RST = 16'h0000;
    localparam logic [MV_W-1:0]    MV_RST    = 32'h0000_0000;
    // Cycles a tuning run lasts, less one, in the unit model of the algorithm.
    localparam int unsigned TUNE_CYC   = 16;
    localparam logic [1:0] MODE_AUTO   = 2'h0;
    typedef enum logic [1:0]
    {
        TMH_BOOT  = 2'b00,
        TMH_IDLE  = 2'b01,
        TMH_TUNE  = 2'b10,
        TMH_STORE = 2'b11
    } tmh_state_t;
endpackage : tmh_pkg
`default_nettype wire

// [inc/tmh_if.sv]
// Cyclic process data link between the unit and the host controller.
`timescale 1ns/1ns
`default_nettype none
interface tmh_if;
    // Host to unit: operation commands and output data.
    logic [3:0]  tune_req;
    logic        reflect_adjust;
    logic        auto_or_manual;
    logic        reflect_manual_mv;
    logic [31:0] manual_mv;
    logic [15:0] out_param;
    logic        save_to_coupler;
    // Unit to host: operating status and input data.
    logic        io_ready;
    logic [3:0]  tune_status;
    logic        param_updated;
    logic        auto_or_manual_status;
    logic        reflect_manual_mv_status;
    logic [31:0] mv_monitor;
    logic [15:0] in_param;
    modport unit
    (
        input  tune_req, reflect_adjust, auto_or_manual, reflect_manual_mv,
        input  manual_mv, out_param, save_to_coupler,
        output io_ready, tune_status, param_updated, auto_or_manual_status,
        output reflect_manual_mv_status, mv_monitor, in_param
    );
    modport host
    (
        output tune_req, reflect_adjust, auto_or_manual, reflect_manual_mv,
        output manual_mv, out_param, save_to_coupler,
        input  io_ready, tune_status, param_updated, auto_or_manual_status,
        input  reflect_manual_mv_status, mv_monitor, in_param
    );
endinterface : tmh_if
`default_nettype wire

// [core/tmh_unit.sv]
// Temperature unit end of the tuning and manual output handshake.
`timescale 1ns/1ns
`default_nettype none
module tmh_unit
#(
    parameter int unsigned TUNE_CYC = tmh_pkg::TUNE_CYC
)
(
    // Clock and reset.
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    // Host link.
    tmh_if.unit                              link,
    // Non-volatile memory and coupler side.
    input  wire logic                        i_io_enable,
    input  wire logic                        i_coupler_has_param,
    input  wire logic [tmh_pkg::PARAM_W-1:0] i_coupler_param,
    input  wire logic [tmh_pkg::PARAM_W-1:0] i_tuned_param,
    input  wire logic [tmh_pkg::MV_W-1:0]    i_auto_mv,
    output logic                             o_nvm_write,
    output logic [tmh_pkg::PARAM_W-1:0]      o_nvm_param,
    output logic                             o_coupler_write,
    output logic [tmh_pkg::PARAM_W-1:0]      o_coupler_param,
    output logic [tmh_pkg::MV_W-1:0]         o_applied_mv
);
    ////////////////////////////////////////////////////////////////////////
    tmh_pkg::tmh_state_t               state_q, state_d;
    logic                              factory_q;
    logic [tmh_pkg::PARAM_W-1:0]       param_q;
    logic [tmh_pkg::N_TUNE-1:0]        status_q;
    logic [tmh_pkg::N_TUNE-1:0]        req_q;
    logic                              upd_q;
    logic                              manual_q;
    logic                              reflect_q;
    logic                              io_q;
    logic                              save_q;
    logic [tmh_pkg::MV_W-1:0]          mv_q;
    logic [$clog2(TUNE_CYC+1)-1:0]     cnt_q;
    logic                              nvm_q;
    logic                              cpl_q;

    wire  [tmh_pkg::N_TUNE-1:0] req_rise = link.tune_req & ~req_q;
    wire                        start    = (state_q == tmh_pkg::TMH_IDLE)
                                           && (|req_rise);
    wire                        done     = (state_q == tmh_pkg::TMH_TUNE)
                                           && (cnt_q == '0);
    wire                        adjust   = (state_q == tmh_pkg::TMH_IDLE)
                                           && link.reflect_adjust
                                           && (link.out_param != param_q);
    wire                        save_rise = link.save_to_coupler & ~save_q;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            tmh_pkg::TMH_BOOT:  state_d = tmh_pkg::TMH_IDLE;
            tmh_pkg::TMH_IDLE:  if (start) state_d = tmh_pkg::TMH_TUNE;
            tmh_pkg::TMH_TUNE:  if (done) state_d = tmh_pkg::TMH_STORE;
            tmh_pkg::TMH_STORE: state_d = tmh_pkg::TMH_IDLE;
            default:            state_d = tmh_pkg::TMH_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q   <= tmh_pkg::TMH_BOOT;
            factory_q <= 1'b1;
            param_q   <= tmh_pkg::PARAM_RST;
            status_q  <= '0;
            req_q     <= '0;
            upd_q     <= 1'b0;
            manual_q  <= 1'b0;
            reflect_q <= 1'b0;
            io_q      <= 1'b0;
            save_q    <= 1'b0;
            mv_q      <= tmh_pkg::MV_RST;
            cnt_q     <= '0;
            nvm_q     <= 1'b0;
            cpl_q     <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            req_q   <= link.tune_req;
            save_q  <= link.save_to_coupler;
            io_q    <= i_io_enable && (state_q != tmh_pkg::TMH_BOOT);
            nvm_q   <= 1'b0;
            cpl_q   <= 1'b0;
            // The factory flag is a register that reset sets; after that it is
            // only cleared, by a tuning completion or an adjust, never set again.
            if (state_q == tmh_pkg::TMH_BOOT && factory_q
                && i_coupler_has_param)
            begin
                param_q <= i_coupler_param;
                nvm_q   <= 1'b1;
            end
            if (start)
            begin
                status_q <= req_rise;
                cnt_q    <= ($clog2(TUNE_CYC+1))'(TUNE_CYC);
            end
            else if (state_q == tmh_pkg::TMH_TUNE && cnt_q != '0)
                cnt_q <= cnt_q - 1'b1;
            if (done)
            begin
                status_q  <= '0;
                param_q   <= i_tuned_param;
                nvm_q     <= 1'b1;
                factory_q <= 1'b0;
            end
            else if (adjust)
            begin
                param_q   <= link.out_param;
                nvm_q     <= 1'b1;
                factory_q <= 1'b0;
            end
            // The completion set wins over a save that lands in the same cycle.
            if (done)
                upd_q <= 1'b1;
            else if (save_rise)
                upd_q <= 1'b0;
            if (save_rise)
                cpl_q <= 1'b1;
            manual_q  <= link.auto_or_manual;
            reflect_q <= link.auto_or_manual && link.reflect_manual_mv;
            if (link.auto_or_manual && link.reflect_manual_mv)
                mv_q <= link.manual_mv;
            else if (!link.auto_or_manual)
                mv_q <= i_auto_mv;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // in_param shows zeros until exchange is enabled; mv_monitor is not gated.
    assign link.io_ready                 = io_q;
    assign link.tune_status              = status_q;
    assign link.param_updated            = upd_q;
    assign link.auto_or_manual_status    = manual_q;
    assign link.reflect_manual_mv_status = reflect_q;
    assign link.mv_monitor               = mv_q;
    assign link.in_param = io_q ? param_q : tmh_pkg::PARAM_RST;
    assign o_nvm_write      = nvm_q;
    assign o_nvm_param      = param_q;
    assign o_coupler_write  = cpl_q;
    assign o_coupler_param  = param_q;
    assign o_applied_mv     = mv_q;
endmodule : tmh_unit
`default_nettype wire

// [core/tmh_host.sv]
// Host controller end of the tuning and manual output handshake.
`timescale 1ns/1ns
`default_nettype none
module tmh_host
(
    // Clock and reset.
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    // Unit link.
    tmh_if.host                              link,
    // Operator and program side.
    input  wire logic [tmh_pkg::N_TUNE-1:0]  i_tune_start,
    input  wire logic                        i_manual_request,
    input  wire logic                        i_edit_valid,
    input  wire logic [tmh_pkg::MV_W-1:0]    i_edit_mv,
    input  wire logic                        i_param_write,
    input  wire logic [tmh_pkg::PARAM_W-1:0] i_param,
    input  wire logic                        i_save,
    output logic                             o_output_edit_permit,
    output logic [tmh_pkg::MV_W-1:0]         o_manual_mv
);
    ////////////////////////////////////////////////////////////////////////
    logic [tmh_pkg::N_TUNE-1:0]   req_q;
    logic                         adj_q;
    logic                         am_q;
    logic                         refl_q;
    logic [tmh_pkg::MV_W-1:0]     mv_q;
    logic [tmh_pkg::PARAM_W-1:0]  par_q;
    logic                         save_q;
    logic                         prev_q;
    logic                         permit_q;

    wire ready   = link.io_ready;
    wire manual  = ready && i_manual_request && link.auto_or_manual_status;
    wire to_man  = manual && !prev_q;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            req_q    <= '0;
            adj_q    <= 1'b0;
            am_q     <= 1'b0;
            refl_q   <= 1'b0;
            mv_q     <= tmh_pkg::MV_RST;
            par_q    <= tmh_pkg::PARAM_RST;
            save_q   <= 1'b0;
            prev_q   <= 1'b0;
            permit_q <= 1'b0;
        end
        else
        begin
            prev_q <= link.auto_or_manual_status;
            save_q <= ready && i_save;
            // Hold each request until its status shows executing.
            req_q  <= ready ? ((req_q | i_tune_start) & ~link.tune_status)
                            : '0;
            adj_q  <= 1'b0;
            if (ready && i_param_write)
            begin
                par_q <= i_param;
                adj_q <= 1'b1;
            end
            else if (ready)
                par_q <= link.in_param;
            am_q <= ready && i_manual_request;
            refl_q <= manual;
            permit_q <= manual && link.reflect_manual_mv_status;
            if (to_man)
                mv_q <= link.mv_monitor;
            else if (permit_q && i_edit_valid)
                mv_q <= i_edit_mv;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.tune_req          = req_q;
    assign link.reflect_adjust    = adj_q;
    assign link.auto_or_manual    = am_q;
    assign link.reflect_manual_mv = refl_q;
    assign link.manual_mv         = mv_q;
    assign link.out_param         = par_q;
    assign link.save_to_coupler   = save_q;
    assign o_output_edit_permit   = permit_q;
    assign o_manual_mv            = mv_q;
endmodule : tmh_host
`default_nettype wire

// [test/tmh_properties.sv]
// Concurrent checks on the link between the unit and the host.
`timescale 1ns/1ns
`default_nettype none
module tmh_properties
#(
    parameter int TUNE_CYC = 16
)
(
    // Clock and reset.
    input wire logic        i_clk,
    input wire logic        i_rst,
    // Link signals.
    input wire logic [3:0]  tune_req,
    input wire logic [3:0]  tune_status,
    input wire logic        param_updated,
    input wire logic        save_to_coupler,
    input wire logic        auto_or_manual,
    input wire logic        auto_or_manual_status,
    input wire logic        reflect_manual_mv,
    input wire logic [31:0] manual_mv,
    input wire logic [31:0] mv_monitor,
    input wire logic        io_ready,
    input wire logic [15:0] in_param,
    input wire logic [15:0] out_param
);
    // A little slack on the run length keeps the check robust to the
    // exact edge the unit counts from, yet still catches a stuck count.
    localparam int RUN_LO = TUNE_CYC;
    localparam int RUN_HI = TUNE_CYC + 2;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////
    tune_set_a: assert property (io_ready && tune_status == 4'h0
        && $onehot(tune_req) && $past(tune_req) == 4'h0
        |=> tune_status == $past(tune_req)) else $error("status not set");
    req_hold_a: assert property (tune_req != 4'h0
        && (tune_req & tune_status) == 4'h0 |=> tune_req == $past(tune_req))
        else $error("request dropped early");
    req_clear_a: assert property ((tune_req & tune_status) != 4'h0
        |=> tune_req == 4'h0) else $error("request not cleared");
    run_len_a: assert property ($rose(tune_status != 4'h0)
        |-> ##[RUN_LO:RUN_HI] $fell(tune_status != 4'h0))
        else $error("tuning run length wrong");
    done_flag_a: assert property ($fell(tune_status != 4'h0)
        |-> param_updated) else $error("updated flag not raised");
    save_clr_a: assert property (save_to_coupler && tune_status == 4'h0
        |=> !param_updated) else $error("updated flag not cleared");
    start_auto_a: assert property (!io_ready && !$past(io_ready)
        |-> !auto_or_manual && !reflect_manual_mv) else $error("not automatic");
    seed_mv_a: assert property ($rose(auto_or_manual_status)
        |=> manual_mv == $past(mv_monitor) && reflect_manual_mv)
        else $error("manual value not seeded");
    mode_follow_a: assert property (io_ready && $changed(auto_or_manual)
        |=> auto_or_manual_status == $past(auto_or_manual))
        else $error("mode status not following");
    copy_out_a: assert property ($rose(io_ready)
        |-> ##[1:3] out_param == in_param) else $error("output not copied");
    cover property ($fell(tune_status != 4'h0));
    cover property ($rose(auto_or_manual_status));
    cover property (save_to_coupler && param_updated);
endmodule : tmh_properties
`default_nettype wire

// [test/tmh_test.sv]
// Self-checking bench joining the unit and host ends.
`timescale 1ns/1ns
`default_nettype none
module tmh_test;
    localparam int TC = 2;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [15:0] i_cpar = 16'h0000, i_tuned = 16'h0000, i_param = 16'h0000;
    logic [31:0] i_auto_mv = 32'h0, i_edit_mv = 32'h0;
    logic [3:0]  i_tune_start = 4'h0;
    logic        i_man = 1'b0, i_edit = 1'b0, i_pwr = 1'b0, i_save = 1'b0;
    logic        o_nvm_write, o_permit, o_cpl_write;
    int          cpl_cnt = 0;
    logic [15:0] o_nvm_param, o_coupler_param;
    logic [31:0] o_applied_mv, o_manual_mv;
    int          errors = 0, n_checks = 0, i, k, nvm_cnt = 0, base;
    int          exp_par, exp_mv;
    tmh_if link ();
    tmh_unit #(.TUNE_CYC(TC)) tmh_unit_i (.i_clk(i_clk), .i_rst(i_rst),
        .link(link.unit), .i_io_enable(1'b1), .i_coupler_has_param(1'b1),
        .i_coupler_param(i_cpar), .i_tuned_param(i_tuned),
        .i_auto_mv(i_auto_mv), .o_nvm_write(o_nvm_write),
        .o_nvm_param(o_nvm_param), .o_coupler_write(o_cpl_write),
        .o_coupler_param(o_coupler_param), .o_applied_mv(o_applied_mv));
    tmh_host tmh_host_i (.i_clk(i_clk), .i_rst(i_rst), .link(link.host),
        .i_tune_start(i_tune_start), .i_manual_request(i_man),
        .i_edit_valid(i_edit), .i_edit_mv(i_edit_mv), .i_param_write(i_pwr),
        .i_param(i_param), .i_save(i_save), .o_output_edit_permit(o_permit),
        .o_manual_mv(o_manual_mv));
    tmh_properties #(.TUNE_CYC(TC)) tmh_properties_i (.i_clk(i_clk),
        .i_rst(i_rst), .tune_req(link.tune_req),
        .tune_status(link.tune_status), .param_updated(link.param_updated),
        .save_to_coupler(link.save_to_coupler),
        .auto_or_manual(link.auto_or_manual),
        .auto_or_manual_status(link.auto_or_manual_status),
        .reflect_manual_mv(link.reflect_manual_mv),
        .manual_mv(link.manual_mv), .mv_monitor(link.mv_monitor),
        .io_ready(link.io_ready), .in_param(link.in_param),
        .out_param(link.out_param));
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_nvm_write === 1'b1) nvm_cnt <= nvm_cnt + 1;
    always @(posedge i_clk) if (o_cpl_write === 1'b1) cpl_cnt <= cpl_cnt + 1;
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_clk);
        #10;
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen,
                         input int exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    task automatic guard(input int n);
        if (n >= 60)
        begin
            errors++;
            $display("Error wait timed out");
            summarize();
        end
    endtask : guard
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(5));
        i_cpar = 16'($urandom);
        exp_par = i_cpar;
        tick(2);
        i_rst = 1'b0;
        for (i = 0; i < 60 && link.io_ready !== 1'b1; i++) tick();
        guard(i);
        tick(3);
        base = nvm_cnt;
        check("in_param", link.in_param, exp_par);
        check("out_param", link.out_param, exp_par);
        check("mode_cmd", link.auto_or_manual, 0);
        check("permit", o_permit, 0);
        $display("test boot done");
        for (k = 0; k < 4; k++)
        begin
            i_tuned = 16'($urandom);
            exp_par = i_tuned;
            i_tune_start[k] = 1'b1;
            tick();
            i_tune_start = 4'h0;
            for (i = 0; i < 60 && link.tune_status[k] !== 1'b1; i++) tick();
            guard(i);
            check("status", link.tune_status, 1 << k);
            for (i = 0; i < 60 && link.tune_status[k] !== 1'b0; i++) tick();
            guard(i);
            check("updated", link.param_updated, 1);
            check("nvm_param", o_nvm_param, exp_par);
            check("in_param", link.in_param, exp_par);
            i_save = 1'b1;
            tick();
            i_save = 1'b0;
            tick(3);
            check("updated", link.param_updated, 0);
            check("coupler", o_coupler_param, exp_par);
            check("out_param", link.out_param, exp_par);
        end
        check("coupler_writes", 32'(cpl_cnt), 4);
        $display("test tuning done");
        i_param = 16'($urandom);
        exp_par = i_param;
        i_pwr = 1'b1;
        tick();
        i_pwr = 1'b0;
        tick(4);
        check("in_param", link.in_param, exp_par);
        check("nvm_param", o_nvm_param, exp_par);
        check("nvm_writes", 32'(nvm_cnt - base), 5);
        $display("test reflect done");
        i_auto_mv = $urandom;
        exp_mv = i_auto_mv;
        i_edit_mv = $urandom;
        i_edit = 1'b1;
        tick();
        i_edit = 1'b0;
        check("manual_mv", o_manual_mv, 0);
        i_man = 1'b1;
        for (i = 0; i < 60 && o_permit !== 1'b1; i++) tick();
        guard(i);
        check("mode", link.auto_or_manual_status, 1);
        check("manual_mv", o_manual_mv, exp_mv);
        check("reflect", link.reflect_manual_mv, 1);
        i_edit_mv = $urandom;
        exp_mv = i_edit_mv;
        i_edit = 1'b1;
        tick();
        i_edit = 1'b0;
        tick(4);
        check("applied", o_applied_mv, exp_mv);
        i_man = 1'b0;
        tick(4);
        check("mode", link.auto_or_manual_status, 0);
        $display("test manual done");
        summarize();
    end
endmodule : tmh_test
`default_nettype wire
